// [verilog/tpb_pkg.sv]
/*
  Constants, field layout and carrier types of the timer/pwm block.
  Assumes a single 100 MHz clock and an APB register bus.
*/
//------------------------------------------------------------------
// Overview of operation
// R01: edge pwm value waits for both bytes, loads at count modulus-1 to modulus
// R02: free-running counter loads buffered pwm value stepping 0xfffe to 0xffff
// R03: centre pwm value waits for both bytes, loads at modulus-1 to modulus
// R04: centre pwm with value equal to modulus gives full duty
// R05: centre pwm with value modulus minus one gives near-full duty, never zero
// R06: centre pwm value leaving zero applies only from a fresh period
// R07: centre pwm value going to zero finishes the period with old duty
// R08: control write during debug halt clears modulus byte pairing
// R09: any control write clears channel value byte pairing
// R10: software should write module control before channel values
// R11: three modules: one with four channels, two with two
// R12: each channel is capture, compare or edge pwm
// R13: capture on rising, falling or either pin edge
// R14: compare match sets, clears or toggles the pin
// R15: pwm polarity selectable per channel
// R16: module switch puts all channels with non-zero els into centre pwm; els zero turns a channel off
// R17: prescaler source is bus clock, fixed tick or external pin
// R18: prescaler divides by 1 to 128 in powers of two
// R19: 16-bit counter, up or up/down for centre pwm
// R20: one external timer clock shared by all modules
// R21: counter write clears counter and prescaler
// R22: centre pwm: active on down match, inactive on up match
// R23: no clock source: counter stops, value loads on second byte
//------------------------------------------------------------------
package tpb_pkg;
  localparam int NUM_MOD  = 3;
  localparam int MAX_CH   = 4;
  localparam int NCH      [NUM_MOD] = '{4, 2, 2};
  localparam int PIN_BASE [NUM_MOD] = '{0, 4, 6};

  // register offsets inside one module window
  localparam logic [5:0] OFF_SC   = 6'h00;
  localparam logic [5:0] OFF_CNT  = 6'h04;
  localparam logic [5:0] OFF_MOD  = 6'h08;
  localparam logic [5:0] OFF_CH0  = 6'h10;
  localparam logic [5:0] CH_SPAN  = 6'h20;

  // field positions
  localparam int SC_OVF_BIT   = 7;
  localparam int CSC_FLAG_BIT = 7;

  // clock source codes
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_BUS  = 2'h1;
  localparam logic [1:0] CLK_FIX  = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

  // reset values and counter limits
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [15:0] RST_MOD  = 16'h0000;
  localparam logic [15:0] RST_CV   = 16'h0000;
  localparam logic [15:0] FREE_TOP = 16'hffff;

  typedef struct packed {
    logic       center_aligned_pwm;
    logic [1:0] clk;
    logic [2:0] ps;
  } tpb_modcfg_type;

  typedef struct packed {
    logic [1:0] ms;
    logic [1:0] els;
  } tpb_chcfg_type;

  localparam tpb_modcfg_type RST_MODCFG = 6'h00;
  localparam tpb_chcfg_type  RST_CHCFG  = 4'h0;

  typedef enum logic [2:0] {
    CH_OFF, CH_CAPTURE, CH_COMPARE, CH_EPWM, CH_CENTER_ALIGNED_PWM
  } tpb_chmode_type;

  function automatic tpb_chmode_type chan_mode(
    input tpb_chcfg_type c,
    input logic          center_aligned_pwm
  );
    if (center_aligned_pwm)
      chan_mode = (c.els == 2'h0) ? CH_OFF : CH_CENTER_ALIGNED_PWM;
    else if (c.ms[1])
      chan_mode = CH_EPWM;
    else if (c.ms[0])
      chan_mode = CH_COMPARE;
    else
      chan_mode = (c.els == 2'h0) ? CH_OFF : CH_CAPTURE;
  endfunction : chan_mode

  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction : ps_mask
endpackage : tpb_pkg

// [verilog/tpb_timer_pwm.sv]
/*
  Three timer/pwm modules behind one APB slave, eight channel pins.
  Assumes pin inputs and tick inputs are synchronous to i_mclk.
*/
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tpb_timer_pwm (
  input  wire logic        i_mclk,                  // 100 MHz clock
  input  wire logic        i_sys_rst,               // sync reset, high
  input  wire logic [7:0]  i_paddr,                 // apb byte address
  input  wire logic        i_psel,                  // apb select
  input  wire logic        i_penable,               // apb enable
  input  wire logic        i_pwrite,                // apb write
  input  wire logic [31:0] i_pwdata,                // apb write data
  input  wire logic [3:0]  i_pstrb,                 // apb byte lanes
  output logic      [31:0] o_prdata,                // apb read data
  output logic             o_pready,                // apb ready
  output logic             o_pslverr,               // apb error
  input  wire logic        i_fixed_tick,            // fixed clock tick
  input  wire logic        i_external_timer_clock,  // shared ext clock
  input  wire logic        i_background_debug_halt, // debug halt
  input  wire logic [7:0]  i_ch_pin,                // pin levels in
  output wire logic [7:0]  o_ch_pin,                // pin drive level
  output wire logic [7:0]  o_ch_oe                  // pin drive enable
);

  //----------------------------------------------------------------
  // bus decode
  //----------------------------------------------------------------
  logic [31:0] rdata_r;
  logic        err_r;
  logic        ext_prev_r;

  wire         halt     = i_background_debug_halt;
  wire         wr_acc   = i_psel & i_penable & i_pwrite;
  wire         setup    = i_psel & ~i_penable;
  wire [1:0]   a_mod    = i_paddr[7:6];
  wire [5:0]   a_off    = i_paddr[5:0];
  wire [5:0]   a_rel    = 6'(a_off - tpb_pkg::OFF_CH0);
  wire         a_isch   = (a_off >= tpb_pkg::OFF_CH0)
                        & (a_rel < tpb_pkg::CH_SPAN);
  wire [1:0]   a_ch     = a_rel[4:3];
  wire         a_isv    = a_rel[2];
  wire         a_algn   = (i_paddr[1:0] == 2'h0);
  wire         stb_lo   = i_pstrb[0];
  wire         stb_hi   = i_pstrb[1];
  // one edge detector feeds every module
  wire         ext_tick = i_external_timer_clock & ~ext_prev_r; // R20

  wire [31:0]  rd_mod  [tpb_pkg::NUM_MOD];
  wire         hit_mod [tpb_pkg::NUM_MOD];
  wire         mod_ok   = (a_mod != 2'h3);
  // module 3 has no window; the guard keeps both indices in range
  wire [1:0]   a_modi   = mod_ok ? a_mod : 2'h0;
  wire         hit      = a_algn & mod_ok & hit_mod[a_modi];
  wire [31:0]  rd_sel   = hit ? rd_mod[a_modi] : 32'h0000_0000;

  // every access ends in its first access cycle; no wait states
  assign o_pready  = 1'b1;
  assign o_prdata  = rdata_r;
  assign o_pslverr = err_r & i_psel & i_penable;

  // read data is sampled in setup so the access phase needs no wait
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      rdata_r    <= 32'h0000_0000;
      err_r      <= 1'b0;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_prev_r <= i_external_timer_clock;
      if (setup)
      begin
        rdata_r <= rd_sel;
        err_r   <= ~hit;
      end
    end
  end

  //----------------------------------------------------------------
  // timer modules
  //----------------------------------------------------------------
  for (genvar m = 0; m < tpb_pkg::NUM_MOD; m++)
  begin : g_mod // R11
    localparam logic [2:0] NC = 3'(tpb_pkg::NCH[m]);

    tpb_pkg::tpb_modcfg_type cfg_r;
    logic [15:0] cnt_r;
    logic [15:0] mod_r;
    logic [15:0] mbuf_r;
    logic [6:0]  presc_r;
    logic        down_r;
    logic        mlo_r;
    logic        mhi_r;
    logic        ovf_r;

    wire [31:0]  rd_ch [tpb_pkg::MAX_CH];

    wire         sel    = (a_mod == 2'(m)) & a_algn;
    wire         w_sc   = wr_acc & sel & (a_off == tpb_pkg::OFF_SC);
    wire         w_cnt  = wr_acc & sel & (a_off == tpb_pkg::OFF_CNT);
    wire         w_mod  = wr_acc & sel & (a_off == tpb_pkg::OFF_MOD);
    wire         clk_on = (cfg_r.clk != tpb_pkg::CLK_NONE);

    // zero and all-ones both mean free running
    wire         free   = (mod_r == 16'h0000)
                        | (mod_r == tpb_pkg::FREE_TOP);
    wire [15:0]  top    = free ? tpb_pkg::FREE_TOP : mod_r;

    wire         src    = (cfg_r.clk == tpb_pkg::CLK_BUS) ? 1'b1 :
                          (cfg_r.clk == tpb_pkg::CLK_FIX) ? i_fixed_tick :
                          (cfg_r.clk == tpb_pkg::CLK_EXT) ? ext_tick :
                          1'b0; // R17 R23
    wire [6:0]   pmask  = tpb_pkg::ps_mask(cfg_r.ps);
    // counting freezes while the processor is halted
    wire         run    = src & ~halt;
    wire         step   = run & ((presc_r & pmask) == pmask); // R18

    wire         at_top  = (cnt_r == top);
    wire         at_zero = (cnt_r == 16'h0000);
    wire         turn_dn = cfg_r.center_aligned_pwm & ~down_r & at_top;
    wire         turn_up = cfg_r.center_aligned_pwm & down_r & at_zero;
    wire         down_nx = cfg_r.center_aligned_pwm & (turn_dn | (down_r & ~turn_up));
    wire [15:0]  cnt_inc = 16'(cnt_r + 16'h0001);
    wire [15:0]  cnt_dec = 16'(cnt_r - 16'h0001);
    wire [15:0]  cnt_nxt = ~cfg_r.center_aligned_pwm ? (at_top ? 16'h0000 : cnt_inc)
                         : (down_nx ? cnt_dec : cnt_inc); // R19 R22
    wire         wrap    = cfg_r.center_aligned_pwm ? turn_up : at_top;
    // buffered pwm values move only on the step into the top count
    wire [15:0]  top_m1  = 16'(top - 16'h0001);
    wire         upd_pt  = step & (cnt_r == top_m1)
                         & (cnt_nxt == top); // R01 R02 R03

    wire [15:0]  mod_val = {stb_hi ? i_pwdata[15:8] : mbuf_r[15:8],
                            stb_lo ? i_pwdata[7:0]  : mbuf_r[7:0]};
    wire         mod_done = w_mod & (mlo_r | stb_lo) & (mhi_r | stb_hi);
    wire         ovf_clr  = w_sc & stb_lo & i_pwdata[tpb_pkg::SC_OVF_BIT];

    always_ff @(posedge i_mclk)
    begin
      if (i_sys_rst)
      begin
        cfg_r   <= tpb_pkg::RST_MODCFG;
        cnt_r   <= tpb_pkg::RST_CNT;
        presc_r <= 7'h00;
        down_r  <= 1'b0;
        ovf_r   <= 1'b0;
      end
      else
      begin
        if (w_sc & stb_lo)
          cfg_r <= i_pwdata[5:0]; // R16 R17 R18
        if (w_cnt)
        begin
          cnt_r   <= tpb_pkg::RST_CNT; // R21
          presc_r <= 7'h00;            // R21
          down_r  <= 1'b0;
        end
        else if (run)
        begin
          presc_r <= 7'(presc_r + 7'h01);
          if (step)
          begin
            cnt_r  <= cnt_nxt;
            down_r <= down_nx;
          end
        end
        // a wrap in the clearing cycle is kept
        ovf_r <= (step & wrap) | (ovf_r & ~ovf_clr);
      end
    end

    // modulus byte pairing; the modulus is not buffered, it takes effect
    // in the cycle after the pair completes
    always_ff @(posedge i_mclk)
    begin
      if (i_sys_rst)
      begin
        mod_r  <= tpb_pkg::RST_MOD;
        mbuf_r <= tpb_pkg::RST_MOD;
        mlo_r  <= 1'b0;
        mhi_r  <= 1'b0;
      end
      else if (w_sc & halt)
      begin
        mlo_r <= 1'b0; // R08
        mhi_r <= 1'b0; // R08
      end
      else if (mod_done)
      begin
        mod_r <= mod_val;
        mlo_r <= 1'b0;
        mhi_r <= 1'b0;
      end
      else if (w_mod)
      begin
        mbuf_r <= mod_val;
        mlo_r  <= mlo_r | stb_lo;
        mhi_r  <= mhi_r | stb_hi;
      end
    end

    assign hit_mod[m] = (a_off == tpb_pkg::OFF_SC)
                      | (a_off == tpb_pkg::OFF_CNT)
                      | (a_off == tpb_pkg::OFF_MOD)
                      | (a_isch & ({1'b0, a_ch} < NC));
    assign rd_mod[m]  =
      (a_off == tpb_pkg::OFF_SC)  ? {24'h0, ovf_r, 1'b0, cfg_r} :
      (a_off == tpb_pkg::OFF_CNT) ? {16'h0, cnt_r} :
      (a_off == tpb_pkg::OFF_MOD) ? {16'h0, mod_r} :
      a_isch ? rd_ch[a_ch] : 32'h0000_0000;

    //--------------------------------------------------------------
    // channels
    //--------------------------------------------------------------
    for (genvar c = 0; c < tpb_pkg::MAX_CH; c++)
    begin : g_ch
      if (c < tpb_pkg::NCH[m])
      begin : g_on
        localparam int P = tpb_pkg::PIN_BASE[m] + c;

        tpb_pkg::tpb_chcfg_type  csc_r;
        tpb_pkg::tpb_chmode_type md;
        logic [15:0] cv_r;
        logic [15:0] vbuf_r;
        logic        vlo_r;
        logic        vhi_r;
        logic        pend_r;
        logic        flag_r;
        logic        prev_r;
        logic        out_r;
        logic        oe_r;

        wire         chsel = sel & a_isch & (a_ch == 2'(c));
        wire         w_csc = wr_acc & chsel & ~a_isv;
        wire         w_cv  = wr_acc & chsel & a_isv;
        wire         pin   = i_ch_pin[P];

        assign md = tpb_pkg::chan_mode(csc_r, cfg_r.center_aligned_pwm); // R12 R16

        wire         is_pwm = (md == tpb_pkg::CH_EPWM)
                            | (md == tpb_pkg::CH_CENTER_ALIGNED_PWM);
        wire         ev_cap = (md == tpb_pkg::CH_CAPTURE)
                            & ((csc_r.els[0] & pin & ~prev_r)
                            |  (csc_r.els[1] & ~pin & prev_r)); // R13
        // compare acts on the step that lands on the value
        wire         match  = step & (cnt_nxt == cv_r);
        // value writes are refused while capturing
        wire         v_ok   = w_cv & (md != tpb_pkg::CH_CAPTURE);
        wire [15:0]  v_val  = {stb_hi ? i_pwdata[15:8] : vbuf_r[15:8],
                               stb_lo ? i_pwdata[7:0]  : vbuf_r[7:0]};
        wire         v_done = v_ok & (vlo_r | stb_lo) & (vhi_r | stb_hi);
        wire         v_now  = v_done & ~clk_on; // R23
        wire         xfer   = pend_r & (~clk_on
                            | (is_pwm ? upd_pt : step)); // R01 R02 R03
        wire         f_set  = ev_cap | (match & (md == tpb_pkg::CH_COMPARE
                            | md == tpb_pkg::CH_EPWM));
        wire         f_clr  = w_csc & stb_lo
                            & i_pwdata[tpb_pkg::CSC_FLAG_BIT];
        // edge pwm: active from the period start until the count meets cv
        wire         e_act  = (cnt_r < cv_r);
        // a value at or above the top never goes inactive
        wire         c_act  = (cnt_r < cv_r)
                            | (cv_r >= top); // R04 R05 R22
        wire         act    = (md == tpb_pkg::CH_CENTER_ALIGNED_PWM) ? c_act : e_act;
        wire         oc_nxt = (csc_r.els == 2'h1) ? ~out_r :
                              csc_r.els[1] & csc_r.els[0]; // R14

        always_ff @(posedge i_mclk)
        begin
          if (i_sys_rst)
          begin
            csc_r  <= tpb_pkg::RST_CHCFG;
            prev_r <= 1'b0;
            flag_r <= 1'b0;
          end
          else
          begin
            prev_r <= pin;
            if (w_csc & stb_lo)
              csc_r <= i_pwdata[3:0];
            flag_r <= f_set | (flag_r & ~f_clr);
          end
        end

        // value pairing and buffered load
        always_ff @(posedge i_mclk)
        begin
          if (i_sys_rst)
          begin
            cv_r   <= tpb_pkg::RST_CV;
            vbuf_r <= tpb_pkg::RST_CV;
            vlo_r  <= 1'b0;
            vhi_r  <= 1'b0;
            pend_r <= 1'b0;
          end
          else
          begin
            if (ev_cap)
              cv_r <= cnt_r;
            else if (v_now)
              cv_r <= v_val; // R23
            else if (xfer)
              cv_r <= vbuf_r; // R06 R07
            // cleared ahead of the chain, so a control write in the load
            // cycle cannot leave the flag up to load the buffer twice
            if (xfer)
              pend_r <= 1'b0;
            if (w_sc)
            begin
              vlo_r <= 1'b0; // R09
              vhi_r <= 1'b0; // R09
            end
            else if (v_done)
            begin
              vbuf_r <= v_val;
              vlo_r  <= 1'b0;
              vhi_r  <= 1'b0;
              pend_r <= clk_on;
            end
            else
            begin
              if (v_ok)
              begin
                vbuf_r <= v_val;
                vlo_r  <= vlo_r | stb_lo;
                vhi_r  <= vhi_r | stb_hi;
              end
            end
          end
        end

        // pin drive
        always_ff @(posedge i_mclk)
        begin
          if (i_sys_rst)
          begin
            out_r <= 1'b0;
            oe_r  <= 1'b0;
          end
          else
          begin
            // capture and unused channels leave the pin to its pull-up
            oe_r <= (md == tpb_pkg::CH_COMPARE | is_pwm)
                  & (csc_r.els != 2'h0);
            if (is_pwm)
              out_r <= csc_r.els[0] ? ~act : act; // R15
            else if (md == tpb_pkg::CH_COMPARE)
            begin
              if (match)
                out_r <= oc_nxt; // R14
            end
            else
              out_r <= 1'b0;
          end
        end

        assign rd_ch[c] = a_isv ? {16'h0, cv_r}
                        : {24'h0, flag_r, 3'h0, csc_r};
        assign o_ch_pin[P] = out_r;
        assign o_ch_oe[P]  = oe_r;
      end
      else
      begin : g_off
        assign rd_ch[c] = 32'h0000_0000;
      end
    end
  end

endmodule : tpb_timer_pwm
`default_nettype wire

// [test/tpb_timer_pwm_checker.sv]
/*
  Port-level checks of tpb_timer_pwm.
  Bound into the design from the bench top file; single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module tpb_timer_pwm_checker (
  input wire logic        i_mclk,                  // clock
  input wire logic        i_sys_rst,               // reset
  input wire logic [7:0]  i_paddr,                 // address
  input wire logic        i_psel,                  // select
  input wire logic        i_penable,               // enable
  input wire logic        i_pwrite,                // write
  input wire logic [31:0] i_pwdata,                // wdata
  input wire logic [3:0]  i_pstrb,                 // lanes
  input wire logic [31:0] o_prdata,                // rdata
  input wire logic        o_pready,                // ready
  input wire logic        o_pslverr,               // error
  input wire logic        i_fixed_tick,            // tick
  input wire logic        i_external_timer_clock,  // ext clock
  input wire logic        i_background_debug_halt, // halt
  input wire logic [7:0]  i_ch_pin,                // pins in
  input wire logic [7:0]  o_ch_pin,                // pins out
  input wire logic [7:0]  o_ch_oe                  // enables
);
  //--------------------------------
  // apb and pin relations
  //--------------------------------
  wire logic acc = i_psel && i_penable;
  wire logic wr  = acc && i_pwrite;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  AST_ERR_IN_ACCESS:
    assert property (o_pslverr |-> acc) else $error("error off access");
  // missing module must not leak stale read data
  AST_BAD_MODULE:
    assert property (acc && i_paddr[7:6] == 2'h3 |->
      o_pslverr && (i_pwrite || o_prdata == 32'h0)) else $error("mod3");
  AST_MISALIGNED:
    assert property (acc && i_paddr[1:0] != 2'h0 |-> o_pslverr)
      else $error("misaligned answered");
  AST_NO_CHANNEL:
    assert property (acc && i_paddr inside {8'h60, 8'ha0} |-> o_pslverr)
      else $error("missing channel answered");
  AST_CHANNEL_SEEN:
    assert property (acc && i_paddr inside {8'h28, 8'h58, 8'h98} |->
      o_pready && !o_pslverr) else $error("present channel refused");
  AST_OE_HOLD:
    assert property (!wr [*3] |=> $stable(o_ch_oe))
      else $error("enable moved without write");
  AST_HALT_FREEZE:
    assert property ((i_background_debug_halt && !wr) [*4] |=>
      $stable(o_ch_pin)) else $error("pin moved in halt");
  AST_RESET_QUIET:
    assert property ($fell(i_sys_rst) |-> o_ch_oe == 8'h0 &&
      o_ch_pin == 8'h0 && !o_pslverr) else $error("outputs not reset");
endmodule : tpb_timer_pwm_checker
`default_nettype wire

// [test/tpb_pin_model.sv]
/*
  Far side of the channel pins and the two outside tick sources.
  Assumes the bench clock; released pins rest high on pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module tpb_pin_model (
  input  wire logic       i_mclk,    // clock
  input  wire logic [7:0] i_oe,      // device drive enables
  input  wire logic [7:0] i_drv,     // device drive levels
  input  wire logic       i_ext_run, // lets the ext clock run
  output logic      [7:0] o_pin,     // resolved pin levels
  output logic            o_ext_clk, // shared ext clock
  output logic            o_tick     // fixed tick pulse
);
  //--------------------------------
  // pins and clock sources
  //--------------------------------
  logic [2:0] tick_r = 3'h0;
  logic [2:0] ext_r  = 3'h0;
  assign o_pin  = i_drv | ~i_oe;
  assign o_tick = tick_r == 3'h0;
  // parked low when stopped, so no stray edge
  assign o_ext_clk = i_ext_run && ext_r >= 3'h3;
  always_ff @(posedge i_mclk)
  begin
    tick_r <= (tick_r == 3'h4) ? 3'h0 : tick_r + 3'h1;
    ext_r  <= (ext_r == 3'h5) ? 3'h0 : ext_r + 3'h1;
  end
endmodule : tpb_pin_model
`default_nettype wire

// [test/tpb_timer_pwm_tb.sv]
/*
  Self-checking bench of tpb_timer_pwm with the pin model.
  Assumes pins rest on pull-ups; every bus wait is bounded.
*/
`timescale 1ns/1ns
`default_nettype none
module tpb_timer_pwm_tb;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        pen  = 1'b0;
  logic        pwr  = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        halt = 1'b0;
  logic        ext_run = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tick, ext_clk, err, ld, dx;
  logic [7:0]  pin, pout, poe;
  logic [15:0] v, v2, mv, c, cur;
  logic [15:0] nv [2];
  logic [15:0] ov [2] = '{16'h0, 16'h0};
  logic [2:0]  ps;
  logic [7:0]  map_a [5] = '{8'hc0, 8'h60, 8'h01, 8'h2c, 8'h98};
  logic        map_e [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int          e;
  int          mismatches = 0;
  int          comparisons = 0;
  always #5 mclk = ~mclk;
  tpb_timer_pwm DUT (.i_mclk(mclk), .i_sys_rst(rst), .i_paddr(paddr),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fixed_tick(tick),
    .i_external_timer_clock(ext_clk), .i_background_debug_halt(halt),
    .i_ch_pin(pin), .o_ch_pin(pout), .o_ch_oe(poe));
  tpb_pin_model u_pins (.i_mclk(mclk), .i_oe(poe), .i_drv(pout),
    .i_ext_run(ext_run), .o_pin(pin), .o_ext_clk(ext_clk), .o_tick(tick));
  //--------------------------------
  // bus and report tasks
  //--------------------------------
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s", $time, m);
      mismatches++;
    end
  endtask : chk
  // expected level of a high-true pwm pin at count cnt
  function automatic logic duty_on(input logic [15:0] cnt, cv, top,
                                   input logic cen);
    duty_on = cnt < cv || (cen && cv >= top);
  endfunction : duty_on
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    paddr  <= a;
    pwr    <= w;
    pwdata <= d;
    pstrb  <= s;
    psel   <= 1'b1;
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk(32'(pready), 32'h1, "no ready");
    if (pready !== 1'b1)
      test_done();
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(a, 1'b1, {16'h0, d}, 4'hf);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [15:0] x,
                      input string m);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk(rd, {16'h0, x}, m);
  endtask : rchk
  //--------------------------------
  // main sequence
  //--------------------------------
  initial
  begin
    void'($urandom(23335));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (map_a[i])
    begin
      apb(map_a[i], 1'b0, 32'h0, 4'h0);
      chk(32'(err), 32'(map_e[i]), "refusal");
      chk(rd, 32'h0, "reset read");
    end
    // no clock source: a completed pair loads at once
    wr(8'h50, 16'ha);
    wr(8'h58, 16'h9);
    v  = 16'($urandom_range(16'hffff, 16'h0100));
    v2 = 16'($urandom);
    apb(8'h54, 1'b1, {16'h0, v}, 4'h1);
    rchk(8'h54, 16'h0, "half pair loaded");
    wr(8'h40, 16'h0);
    apb(8'h54, 1'b1, {16'h0, v}, 4'h2);
    rchk(8'h54, 16'h0, "stale half kept");
    apb(8'h54, 1'b1, {16'h0, v2}, 4'h1);
    rchk(8'h54, {v[15:8], v2[7:0]}, "pair load");
    wr(8'h5c, v);
    @(posedge mclk);
    chk(32'({pout[5:4], poe[5:4]}), 32'h7, "polarity");
    halt <= 1'b1;
    apb(8'h48, 1'b1, {16'h0, v}, 4'h1);
    wr(8'h40, 16'h0);
    apb(8'h48, 1'b1, {16'h0, v}, 4'h2);
    rchk(8'h48, 16'h0, "halt pair kept");
    apb(8'h48, 1'b1, {16'h0, v}, 4'h1);
    rchk(8'h48, v, "modulus pair");
    // one step per halt release: edge, then centre with full and
    // near-full duty, then to zero, then back from zero
    for (int cp = 0; cp < 4; cp++)
    begin
      mv = 16'($urandom_range(12, 4));
      nv[0] = cp == 1 ? mv : cp == 2 ? 16'h0 : 16'($urandom_range(mv, 1));
      nv[1] = cp == 1 ? 16'(mv - 16'h1) : cp == 2 ? 16'h0
            : 16'($urandom_range(mv, 1));
      wr(8'h80, {10'h0, cp > 0, tpb_pkg::CLK_BUS, 3'h0});
      wr(8'h88, mv);
      wr(8'h84, 16'h0);
      rchk(8'h84, 16'h0, "count clear");
      for (int n = 0; n < 2; n++)
      begin
        wr(8'h90 + 8'(8 * n), 16'ha);
        wr(8'h94 + 8'(8 * n), nv[n]);
      end
      ld = 1'b0;
      repeat (3 * mv)
      begin
        halt <= 1'b0;
        @(posedge mclk);
        halt <= 1'b1;
        apb(8'h84, 1'b0, 32'h0, 4'h0);
        c  = rd[15:0];
        ld = ld || c == mv;
        for (int n = 0; n < 2; n++)
        begin
          cur = ld ? nv[n] : ov[n];
          rchk(8'h94 + 8'(8 * n), cur, "buffer load");
          dx = duty_on(c, cur, mv, cp > 0);
          chk(32'(pout[6 + n]), 32'(dx), "duty");
        end
      end
      ov = nv;
    end
    // each source at a random divider
    halt    <= 1'b0;
    ext_run <= 1'b1;
    for (int s = 1; s < 4; s++)
    begin
      ps = 3'($urandom_range(2, 0));
      wr(8'h00, {11'h0, 2'(s), ps});
      wr(8'h04, 16'h0);
      repeat (600) @(posedge mclk);
      wr(8'h00, 16'h0);
      apb(8'h04, 1'b0, 32'h0, 4'h0);
      e = 603 / (s == 1 ? 1 : s == 2 ? 5 : 6) >> ps;
      chk(32'(rd + 4 > e && rd < e + 4), 32'h1, "rate");
    end
    // compare sets pin 0 on match; pin 1 rises when released to capture
    wr(8'h04, 16'h0);
    wr(8'h10, 16'h7);
    wr(8'h14, 16'h0020);
    wr(8'h00, {11'h0, tpb_pkg::CLK_BUS, 3'h0});
    chk(32'(pout[0]), 32'h0, "compare early");
    repeat (40) @(posedge mclk);
    chk(32'(pout[0]), 32'h1, "compare set");
    wr(8'h00, 16'h0);
    apb(8'h04, 1'b0, 32'h0, 4'h0);
    c = rd[15:0];
    wr(8'h18, 16'h6);
    wr(8'h18, 16'h1);
    repeat (2) @(posedge mclk);
    rchk(8'h1c, c, "capture value");
    rchk(8'h18, 16'h0081, "capture flag");
    test_done();
  end
endmodule : tpb_timer_pwm_tb
bind tpb_timer_pwm tpb_timer_pwm_checker u_chk (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_paddr(i_paddr), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_fixed_tick(i_fixed_tick),
  .i_external_timer_clock(i_external_timer_clock),
  .i_background_debug_halt(i_background_debug_halt),
  .i_ch_pin(i_ch_pin), .o_ch_pin(o_ch_pin), .o_ch_oe(o_ch_oe));
`default_nettype wire
